// file: core/aperture_regs.svh
// Register offsets, field positions, reset values and delay ranges of the
// sampling-clock conditioning registers.
// Assumes a 4-bit register address and 16-bit register data.
`ifndef APERTURE_REGS_SVH
`define APERTURE_REGS_SVH

`define COARSE_OFF     4'hc
`define FINE_OFF       4'hd
`define SYNC_OFF       4'he

`define COARSE_RST     16'h0004
`define FINE_RST       16'h0000
`define SYNC_RST       16'h0003

`define COARSE_LSB     4
`define SEL_BIT        3
`define DCS_BIT        2
`define FINE_LSB       10
`define REF_LSB        7

`define COARSE_MAX_CODE 2431
`define COARSE_MAX_FS   825000
`define FINE_MAX_CODE   63
`define FINE_MAX_FS     2300
`define REF_MAX_CODE    319
`define REF_MAX_FS      1200000

`define COARSE_MAX_Q    12'h97f
`define FINE_MAX_Q      6'h3f
`define REF_MAX_FS_Q    21'h124f80
`define TOTAL_MAX_FS_Q  20'hc9fa4

`endif

// file: core/aperture_pkg.sv
// Types for the sampling-clock conditioning registers.
// Assumes aperture_regs.svh gives the matching offsets and positions.
`default_nettype none

package aperture_pkg;

   typedef struct packed {
      logic [11:0] coarse_code;
      logic        sel;
      logic        dcs;
      logic [1:0]  rsvd;
   } coarse_reg_t;

   typedef struct packed {
      logic [5:0] fine_code;
      logic [9:0] rsvd;
   } fine_reg_t;

   typedef struct packed {
      logic [8:0] ref_code;
      logic [6:0] misc;
   } sync_reg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } bus_req_t;

endpackage : aperture_pkg

`default_nettype wire

// file: core/delay_scale.sv
// Saturating delay code with its delay in femtoseconds.
// Assumes a static code; purely combinational, the caller registers it.
`timescale 1ns/1ps
`default_nettype none

module delay_scale #(
   parameter int unsigned CW       = 12,
   parameter int unsigned FW       = 20,
   parameter int unsigned MAX_CODE = 2431,
   parameter int unsigned MAX_FS   = 825000
) (
   input  wire logic [CW-1:0] code_i,
   input  wire logic          enable_i,
   output logic      [CW-1:0] code_o,
   output logic      [FW-1:0] fs_o
);

   localparam logic [CW-1:0] MAX_C = CW'(MAX_CODE);

   logic [63:0] prod;

   // Linear across the range; codes past the top hold the top delay
   always_comb begin
      prod = 64'h0;
      if (!enable_i) begin
         code_o = '0;
      end else if (code_i > MAX_C) begin
         code_o = MAX_C;
      end else begin
         code_o = code_i;
      end
      prod = (64'(code_o) * 64'(MAX_FS)) / 64'(MAX_CODE);
      fs_o = prod[FW-1:0];
   end

endmodule : delay_scale

`default_nettype wire

// file: core/aperture_delay_sync_control.sv
// Sampling-clock aperture delay, duty-cycle stabilizer and reference-clock
// delay control registers.
// Assumes a simple register port in the core clock domain; the analog delay
// lines downstream take the applied codes and delay figures as static levels.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "aperture_regs.svh"

module aperture_delay_sync_control (
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   output logic             delay_adjust_select_o,
   output logic             duty_cycle_stabilizer_on_o,
   output logic      [11:0] coarse_delay_magnitude_o,
   output logic      [5:0]  fine_delay_magnitude_o,
   output logic      [19:0] aperture_delay_fs_o,
   output logic      [20:0] ref_clock_delay_fs_o,
   output logic      [6:0]  sync_misc_o
);

   aperture_pkg::bus_req_t    req;
   aperture_pkg::coarse_reg_t coarse_q;
   aperture_pkg::coarse_reg_t coarse_d;
   aperture_pkg::fine_reg_t   fine_q;
   aperture_pkg::fine_reg_t   fine_d;
   aperture_pkg::sync_reg_t   sync_q;
   aperture_pkg::sync_reg_t   sync_d;
   logic [15:0]               rdata_d;
   logic [15:0]               rdata_q;

   logic                      wr_coarse;
   logic                      wr_fine;
   logic                      wr_sync;

   logic [11:0]               coarse_code_s;
   logic [19:0]               coarse_fs_s;
   logic [5:0]                fine_code_s;
   logic [19:0]               fine_fs_s;
   logic [20:0]               ref_fs_s;

   logic                      sel_d;
   logic                      sel_q;
   logic                      dcs_d;
   logic                      dcs_q;
   logic [11:0]               coarse_out_d;
   logic [11:0]               coarse_out_q;
   logic [5:0]                fine_out_d;
   logic [5:0]                fine_out_q;
   logic [19:0]               total_d;
   logic [19:0]               total_q;
   logic [20:0]               ref_fs_d;
   logic [20:0]               ref_fs_q;
   logic [6:0]                misc_d;
   logic [6:0]                misc_q;

   assign req.wr    = wr_i;
   assign req.rd    = rd_i;
   assign req.addr  = addr_i;
   assign req.wdata = wdata_i;

   // Address decode
   always_comb begin
      wr_coarse = 1'b0;
      wr_fine   = 1'b0;
      wr_sync   = 1'b0;
      if (req.wr && req.addr == `COARSE_OFF) begin
         wr_coarse = 1'b1;
      end else if (req.wr && req.addr == `FINE_OFF) begin
         wr_fine = 1'b1;
      end else if (req.wr && req.addr == `SYNC_OFF) begin
         wr_sync = 1'b1;
      end
   end

   // Register file; reserved bits are not stored so they always read zero
   always_comb begin
      coarse_d = coarse_q;
      fine_d   = fine_q;
      sync_d   = sync_q;
      if (wr_coarse) begin
         coarse_d.coarse_code = req.wdata[`COARSE_LSB +: 12];
         coarse_d.sel         = req.wdata[`SEL_BIT];
         coarse_d.dcs         = req.wdata[`DCS_BIT];
         coarse_d.rsvd        = 2'h0;
      end
      if (wr_fine) begin
         fine_d.fine_code = req.wdata[`FINE_LSB +: 6];
         fine_d.rsvd      = 10'h000;
      end
      if (wr_sync) begin
         sync_d.ref_code = req.wdata[`REF_LSB +: 9];
         sync_d.misc     = req.wdata[6:0] & 7'h5f;
      end
   end

   // Values live until rewritten or reset
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         coarse_q <= aperture_pkg::coarse_reg_t'(`COARSE_RST);
         fine_q   <= aperture_pkg::fine_reg_t'(`FINE_RST);
         sync_q   <= aperture_pkg::sync_reg_t'(`SYNC_RST);
      end else begin
         coarse_q <= coarse_d;
         fine_q   <= fine_d;
         sync_q   <= sync_d;
      end
   end

   // Read data stands one cycle after the strobe; unmapped reads give zero
   always_comb begin
      rdata_d = 16'h0000;
      if (req.rd && req.addr == `COARSE_OFF) begin
         rdata_d = coarse_q;
      end else if (req.rd && req.addr == `FINE_OFF) begin
         rdata_d = fine_q;
      end else if (req.rd && req.addr == `SYNC_OFF) begin
         rdata_d = sync_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // One scaler per delay line; the select gates both aperture lines
   delay_scale #(
      .CW       (12),
      .FW       (20),
      .MAX_CODE (`COARSE_MAX_CODE),
      .MAX_FS   (`COARSE_MAX_FS)
   ) u_coarse (
      .code_i   (coarse_q.coarse_code),
      .enable_i (coarse_q.sel),
      .code_o   (coarse_code_s),
      .fs_o     (coarse_fs_s)
   );

   delay_scale #(
      .CW       (6),
      .FW       (20),
      .MAX_CODE (`FINE_MAX_CODE),
      .MAX_FS   (`FINE_MAX_FS)
   ) u_fine (
      .code_i   (fine_q.fine_code),
      .enable_i (coarse_q.sel),
      .code_o   (fine_code_s),
      .fs_o     (fine_fs_s)
   );

   delay_scale #(
      .CW       (9),
      .FW       (21),
      .MAX_CODE (`REF_MAX_CODE),
      .MAX_FS   (`REF_MAX_FS)
   ) u_ref (
      .code_i   (sync_q.ref_code),
      .enable_i (1'b1),
      .code_o   (),
      .fs_o     (ref_fs_s)
   );

   // Output stage: one flop after the registers so every output is clean
   always_comb begin
      sel_d        = coarse_q.sel;
      dcs_d        = coarse_q.dcs;
      coarse_out_d = coarse_code_s;
      fine_out_d   = fine_code_s;
      total_d      = coarse_fs_s + fine_fs_s;
      ref_fs_d     = ref_fs_s;
      misc_d       = sync_q.misc;
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sel_q        <= 1'b0;
         dcs_q        <= 1'b1;
         coarse_out_q <= 12'h000;
         fine_out_q   <= 6'h00;
         total_q      <= 20'h00000;
         ref_fs_q     <= 21'h000000;
         misc_q       <= 7'h03;
      end else begin
         sel_q        <= sel_d;
         dcs_q        <= dcs_d;
         coarse_out_q <= coarse_out_d;
         fine_out_q   <= fine_out_d;
         total_q      <= total_d;
         ref_fs_q     <= ref_fs_d;
         misc_q       <= misc_d;
      end
   end

   assign rdata_o                    = rdata_q;
   assign delay_adjust_select_o      = sel_q;
   assign duty_cycle_stabilizer_on_o = dcs_q;
   assign coarse_delay_magnitude_o   = coarse_out_q;
   assign fine_delay_magnitude_o     = fine_out_q;
   assign aperture_delay_fs_o        = total_q;
   assign ref_clock_delay_fs_o       = ref_fs_q;
   assign sync_misc_o                = misc_q;

   // Helper: set once a write to the coarse register has happened since reset
   logic ever_wr_d;
   logic ever_wr_q;

   always_comb begin
      ever_wr_d = ever_wr_q | wr_coarse;
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ever_wr_q <= 1'b0;
      end else begin
         ever_wr_q <= ever_wr_d;
      end
   end

   sequence s_sel_set;
      wr_coarse && req.wdata[`SEL_BIT] ##1 !wr_coarse;
   endsequence

   sequence s_dcs_clear;
      wr_coarse && !req.wdata[`DCS_BIT] ##1 !wr_coarse;
   endsequence

   property p_coarse_follow;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      coarse_q.sel && coarse_q.coarse_code <= `COARSE_MAX_Q
         |=> coarse_delay_magnitude_o == $past(coarse_q.coarse_code);
   endproperty
   a_coarse_follow: assert property (p_coarse_follow)
      else $error("coarse delay code not applied");

   property p_coarse_sat;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      coarse_q.sel && coarse_q.coarse_code > `COARSE_MAX_Q
         |=> coarse_delay_magnitude_o == `COARSE_MAX_Q;
   endproperty
   a_coarse_sat: assert property (p_coarse_sat)
      else $error("coarse delay did not saturate");

   property p_sel_off;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !delay_adjust_select_o |-> coarse_delay_magnitude_o == 12'h000
         && fine_delay_magnitude_o == 6'h00 && aperture_delay_fs_o == 20'h00000;
   endproperty
   a_sel_off: assert property (p_sel_off)
      else $error("aperture delay active without select");

   property p_sel_set;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_sel_set |=> delay_adjust_select_o;
   endproperty
   a_sel_set: assert property (p_sel_set)
      else $error("select write did not enable adjust");

   property p_dcs_clear;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      s_dcs_clear |=> !duty_cycle_stabilizer_on_o;
   endproperty
   a_dcs_clear: assert property (p_dcs_clear)
      else $error("stabilizer still on after clear");

   property p_reset_state;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !ever_wr_q |-> duty_cycle_stabilizer_on_o && !delay_adjust_select_o;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("wrong clock conditioning state after reset");

   property p_fine_follow;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      coarse_q.sel |=> fine_delay_magnitude_o == $past(fine_q.fine_code);
   endproperty
   a_fine_follow: assert property (p_fine_follow)
      else $error("fine delay code not applied");

   property p_fine_gate;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      wr_fine && !coarse_q.sel && !wr_coarse ##1 !wr_coarse
         |=> fine_delay_magnitude_o == 6'h00;
   endproperty
   a_fine_gate: assert property (p_fine_gate)
      else $error("fine delay active without select");

   property p_ref_sat;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      sync_q.ref_code >= 9'h13f |=> ref_clock_delay_fs_o == `REF_MAX_FS_Q;
   endproperty
   a_ref_sat: assert property (p_ref_sat)
      else $error("reference delay not at maximum");

   property p_sum_max;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      coarse_delay_magnitude_o == `COARSE_MAX_Q && fine_delay_magnitude_o == `FINE_MAX_Q
         |-> aperture_delay_fs_o == `TOTAL_MAX_FS_Q;
   endproperty
   a_sum_max: assert property (p_sum_max)
      else $error("aperture delay is not coarse plus fine");

   property p_hold;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      !req.wr |=> $stable(coarse_q) && $stable(fine_q) && $stable(sync_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("register changed without a write");

endmodule : aperture_delay_sync_control

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the sampling-clock conditioning register block.
// Assumes the block answers reads one cycle after the strobe and updates the
// applied outputs one edge after the register write lands.
`timescale 1ns/1ps
`default_nettype none
`include "aperture_regs.svh"

module tb;
   logic        core_clk_i = 1'b0;
   logic        arst_n_i   = 1'b0;
   logic [3:0]  addr_i     = 4'h0;
   logic [15:0] wdata_i    = 16'h0000;
   logic        wr_i       = 1'b0;
   logic        rd_i       = 1'b0;
   logic [15:0] rdata_o;
   logic        sel_o;
   logic        dcs_o;
   logic [11:0] coarse_o;
   logic [5:0]  fine_o;
   logic [19:0] ap_fs_o;
   logic [20:0] ref_fs_o;
   logic [6:0]  misc_o;
   logic [15:0] m_c;
   logic [15:0] m_f;
   logic [15:0] m_s;
   int          errors       = 0;
   int          total_checks = 0;

   always #5 core_clk_i = ~core_clk_i;

   aperture_delay_sync_control i_aperture_delay_sync_control (
      .core_clk_i                 (core_clk_i),
      .arst_n_i                   (arst_n_i),
      .addr_i                     (addr_i),
      .wdata_i                    (wdata_i),
      .wr_i                       (wr_i),
      .rd_i                       (rd_i),
      .rdata_o                    (rdata_o),
      .delay_adjust_select_o      (sel_o),
      .duty_cycle_stabilizer_on_o (dcs_o),
      .coarse_delay_magnitude_o   (coarse_o),
      .fine_delay_magnitude_o     (fine_o),
      .aperture_delay_fs_o        (ap_fs_o),
      .ref_clock_delay_fs_o       (ref_fs_o),
      .sync_misc_o                (misc_o)
   );

   task automatic tally_and_finish();
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
         errors++;
      end
   endtask : chk

   // Reserved bits are never stored, so the model masks them the same way
   function automatic logic [15:0] reg_exp(input logic [3:0] a);
      case (a)
         `COARSE_OFF: reg_exp = m_c;
         `FINE_OFF:   reg_exp = m_f;
         `SYNC_OFF:   reg_exp = m_s;
         default:     reg_exp = 16'h0000;
      endcase
   endfunction : reg_exp

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wr_i    <= 1'b1;
      rd_i    <= 1'b0;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      if (a == `COARSE_OFF) m_c = d & 16'hfffc;
      if (a == `FINE_OFF) m_f = d & 16'hfc00;
      if (a == `SYNC_OFF) m_s = d & 16'hffdf;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      wr_i   <= 1'b0;
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk(21'(rdata_o), 21'(reg_exp(a)));
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(21'(rdata_o), 21'h0);
      @(posedge core_clk_i);
   endtask : rd

   task automatic settle();
      int cc;
      int fc;
      int rc;
      logic s;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      s  = m_c[`SEL_BIT];
      cc = (m_c[15:4] > 2431) ? 2431 : int'(m_c[15:4]);
      fc = s ? int'(m_f[15:10]) : 0;
      cc = s ? cc : 0;
      rc = (m_s[15:7] > 319) ? 319 : int'(m_s[15:7]);
      chk(21'(sel_o), 21'(s));
      chk(21'(dcs_o), 21'(m_c[`DCS_BIT]));
      chk(21'(coarse_o), 21'(cc));
      chk(21'(fine_o), 21'(fc));
      chk(21'(ap_fs_o), 21'(cc * 825000 / 2431 + fc * 2300 / 63));
      chk(ref_fs_o, 21'(rc * 1200000 / 319));
      chk(21'(misc_o), 21'(m_s[6:0]));
      @(posedge core_clk_i);
   endtask : settle

   int          cor[4] = '{0, 2431, 2432, 4095};
   int          rcd[4] = '{0, 319, 320, 511};
   logic [3:0]  a;

   initial begin
      void'($urandom(32'hcc76d57a));
      m_c = `COARSE_RST;
      m_f = `FINE_RST;
      m_s = `SYNC_RST;
      repeat (6) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      settle();
      rd(`COARSE_OFF);
      rd(`FINE_OFF);
      rd(`SYNC_OFF);
      wr(4'h5, 16'hffff);
      rd(4'h5);
      rd(4'h0);
      // Boundary codes; the host keeps coarse bits 1:0 at zero, while the
      // fine and sync reserved bits go in as ones to see them dropped
      for (int i = 0; i < 4; i++) begin
         wr(`COARSE_OFF, {cor[i][11:0], 1'b1, i[0], 2'b00});
         wr(`FINE_OFF, {(i[0] ? 6'h3f : 6'h00), 10'h3ff});
         wr(`SYNC_OFF, {rcd[i][8:0], 7'h7f});
         settle();
         rd(`COARSE_OFF);
         rd(`FINE_OFF);
         rd(`SYNC_OFF);
      end
      // Select cleared with large codes: nothing applied. No sampling clock
      // runs here, so reaching the top codes above is harmless
      wr(`FINE_OFF, 16'hfc00);
      wr(`COARSE_OFF, 16'hfff4);
      settle();
      for (int i = 0; i < 40; i++) begin
         wr(`COARSE_OFF, 16'($urandom()) & 16'hfffc);
         wr(`FINE_OFF, 16'($urandom()));
         wr(`SYNC_OFF, 16'($urandom()));
         settle();
         a = 4'($urandom_range(0, 15));
         rd(a);
      end
      // Reset in mid-run restores the power-on state at once
      wr(`COARSE_OFF, 16'h1238);
      wr_i     <= 1'b0;
      arst_n_i <= 1'b0;
      @(negedge core_clk_i);
      chk(21'(sel_o), 21'h0);
      chk(21'(dcs_o), 21'h1);
      chk(21'(misc_o), 21'h03);
      m_c = `COARSE_RST;
      m_f = `FINE_RST;
      m_s = `SYNC_RST;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      settle();
      rd(`COARSE_OFF);
      tally_and_finish();
   end

   // Cuts a hang short at 500us, over a hundred times the normal run of about 4us
   initial begin
      #500us;
      errors++;
      tally_and_finish();
   end
endmodule : tb

`default_nettype wire
